/* File: cpwm_pkg.sv */
// Constants shared by the complementary PWM counter core
package cpwm_pkg;

    localparam int CNT_W    = 16;
    localparam int PHASES   = 3;
    localparam int ADDR_W   = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_DEAD      = 8'h04;
    localparam logic [7:0] OFF_CYC_BUF   = 8'h08;
    localparam logic [7:0] OFF_CYC_DATA  = 8'h0C;
    localparam logic [7:0] OFF_HALF_BUF  = 8'h10;
    localparam logic [7:0] OFF_HALF_CMP  = 8'h14;
    localparam logic [7:0] OFF_LEAD      = 8'h18;
    localparam logic [7:0] OFF_LAG       = 8'h1C;
    localparam logic [7:0] OFF_SUB       = 8'h20;
    localparam logic [7:0] OFF_DUTY_BUF0 = 8'h30;
    localparam logic [7:0] OFF_DUTY_CMP0 = 8'h40;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_BIT  = 1;
    localparam int CTRL_DTE_BIT   = 2;

    // Values after reset, and a plain zero constant
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [15:0] RST_BUF  = 16'hFFFF;
    localparam logic [15:0] RST_DEAD = 16'h0001;
    localparam logic [15:0] ZERO     = 16'h0000;

    typedef enum logic [2:0] {
        SUB_IDLE      = 3'b000,
        SUB_CREST_DN  = 3'b001,
        SUB_CREST_UP  = 3'b010,
        SUB_TROUGH_UP = 3'b011,
        SUB_TROUGH_DN = 3'b100
    } sub_state_e;

endpackage

/* File: updown_counter.sv */
// Up/down counter that reverses at a top and a bottom match
`timescale 1ns/100ps
`default_nettype none
module updown_counter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    input  wire logic        run,
    input  wire logic [15:0] top,
    input  wire logic [15:0] bottom,
    output logic      [15:0] count,
    output logic             counting_up
);
    logic [15:0] count_next;
    logic        up_next;

    // Reversal steps straight away in the new direction
    assign up_next    = counting_up ? (count != top) : (count == bottom);
    assign count_next = up_next ? count + 16'h0001 : count - 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count       <= cpwm_pkg::RST_CNT;
            counting_up <= 1'b1;
        end else if (load) begin
            count       <= load_value;
            counting_up <= 1'b1;
        end else if (run) begin
            count       <= count_next;
            counting_up <= up_next;
        end
    end
endmodule
`default_nettype wire

/* File: dead_region_subcounter.sv */
// Sub-counter that covers the dead-time regions at crest and trough
`timescale 1ns/100ps
`default_nettype none
module dead_region_subcounter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        crest_start,
    input  wire logic        trough_start,
    input  wire logic [15:0] cycle_data_value,
    input  wire logic [15:0] dead_time_value,
    input  wire logic [15:0] half_cmp,
    output logic      [15:0] count,
    output logic             active,
    output logic             reload_pulse
);
    cpwm_pkg::sub_state_e state_reg;
    cpwm_pkg::sub_state_e state_next;
    logic [15:0]          count_next;

    assign active = (state_reg != cpwm_pkg::SUB_IDLE);

    always_comb begin
        state_next   = state_reg;
        count_next   = count;
        reload_pulse = 1'b0;
        case (state_reg)
            cpwm_pkg::SUB_IDLE: begin
                if (crest_start) begin
                    // Start below half compare: a bare decrement from zero would wrap
                    state_next = cpwm_pkg::SUB_CREST_DN;
                    count_next = half_cmp - 16'h0001;
                end else if (trough_start) begin
                    state_next = cpwm_pkg::SUB_TROUGH_UP;
                    count_next = count + 16'h0001;
                end
            end
            cpwm_pkg::SUB_CREST_DN: begin
                if (count == cycle_data_value) begin
                    state_next = cpwm_pkg::SUB_CREST_UP;
                    count_next = count + 16'h0001;
                end else begin
                    count_next = count - 16'h0001;
                end
            end
            cpwm_pkg::SUB_CREST_UP: begin
                if (count == half_cmp) begin
                    state_next = cpwm_pkg::SUB_IDLE;
                    count_next = cpwm_pkg::ZERO;
                end else begin
                    count_next = count + 16'h0001;
                end
            end
            cpwm_pkg::SUB_TROUGH_UP: begin
                if (count == dead_time_value) begin
                    state_next = cpwm_pkg::SUB_TROUGH_DN;
                    count_next = count - 16'h0001;
                end else begin
                    count_next = count + 16'h0001;
                end
            end
            cpwm_pkg::SUB_TROUGH_DN: begin
                if (count == cpwm_pkg::ZERO) begin
                    state_next   = cpwm_pkg::SUB_IDLE;
                    count_next   = half_cmp;
                    reload_pulse = 1'b1;
                end else begin
                    count_next = count - 16'h0001;
                end
            end
            default: state_next = cpwm_pkg::SUB_IDLE;
        endcase
    end

    // Free of any software load path: no init needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= cpwm_pkg::SUB_IDLE;
            count     <= cpwm_pkg::RST_CNT;
        end else if (run) begin
            state_reg <= state_next;
            count     <= count_next;
        end
    end
endmodule
`default_nettype wire

/* File: complementary_pwm_counters.sv */
// Complementary PWM counter core with APB register access
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module complementary_pwm_counters (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [2:0]  pwm_pos,
    output logic      [2:0]  pwm_neg,
    output logic      [2:0]  duty_match,
    output logic      [2:0]  temp_match
);
    // ==========================================================
    // Register state
    logic        count_start_bit_reg;
    logic        mode_reg;
    logic        dead_time_enable_reg;
    logic [15:0] dead_time_value_reg;
    logic [15:0] cycle_data_buffer_reg;
    logic [15:0] cycle_data_value_reg;
    logic [15:0] half_cycle_buffer_reg;
    logic [15:0] half_cmp_reg;
    logic [15:0] duty_buf_reg  [3];
    logic [15:0] duty_temp_reg [3];
    logic [15:0] duty_cmp_reg  [3];
    logic        mode_prev_reg;
    logic [31:0] prdata_next;
    logic        pslverr_next;

    // ==========================================================
    // Counters
    logic [15:0] lead_counter;
    logic [15:0] lag_counter;
    logic [15:0] sub_count;
    logic        lead_up;
    logic        lag_up;
    logic        sub_active;
    logic        sub_reload;

    wire run        = mode_reg & count_start_bit_reg;
    wire mode_entry = mode_reg & ~mode_prev_reg;
    wire lead_load  = mode_entry & ~count_start_bit_reg;

    // ==========================================================
    // APB decode
    wire setup   = psel & ~penable;
    wire wr_en   = psel & penable & pready & pwrite;
    wire a_ctrl  = (paddr == cpwm_pkg::OFF_CTRL);
    wire a_dead  = (paddr == cpwm_pkg::OFF_DEAD);
    wire a_cbuf  = (paddr == cpwm_pkg::OFF_CYC_BUF);
    wire a_cdat  = (paddr == cpwm_pkg::OFF_CYC_DATA);
    wire a_hbuf  = (paddr == cpwm_pkg::OFF_HALF_BUF);
    wire a_hcmp  = (paddr == cpwm_pkg::OFF_HALF_CMP);
    wire a_lead  = (paddr == cpwm_pkg::OFF_LEAD);
    wire a_lag   = (paddr == cpwm_pkg::OFF_LAG);
    wire a_sub   = (paddr == cpwm_pkg::OFF_SUB);
    wire [7:0] duty_buf_off = paddr - cpwm_pkg::OFF_DUTY_BUF0;
    wire [7:0] duty_cmp_off = paddr - cpwm_pkg::OFF_DUTY_CMP0;
    wire a_dbuf  = (duty_buf_off[7:4] == 4'h0) && (duty_buf_off[1:0] == 2'h0)
                   && (duty_buf_off[3:2] != 2'h3);
    wire a_dcmp  = (duty_cmp_off[7:4] == 4'h0) && (duty_cmp_off[1:0] == 2'h0)
                   && (duty_cmp_off[3:2] != 2'h3);
    wire [1:0] dbuf_idx = duty_buf_off[3:2];
    wire [1:0] dcmp_idx = duty_cmp_off[3:2];

    // Zero wait states; read data is registered in the setup cycle
    assign pready = 1'b1;

    always_comb begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (a_ctrl) begin
            prdata_next[cpwm_pkg::CTRL_START_BIT] = count_start_bit_reg;
            prdata_next[cpwm_pkg::CTRL_MODE_BIT]  = mode_reg;
            prdata_next[cpwm_pkg::CTRL_DTE_BIT]   = dead_time_enable_reg;
        end else if (a_dead) begin
            prdata_next[15:0] = dead_time_value_reg;
        end else if (a_cbuf) begin
            prdata_next[15:0] = cycle_data_buffer_reg;
        end else if (a_cdat) begin
            prdata_next[15:0] = cycle_data_value_reg;
        end else if (a_hbuf) begin
            prdata_next[15:0] = half_cycle_buffer_reg;
        end else if (a_hcmp) begin
            prdata_next[15:0] = half_cmp_reg;
        end else if (a_lead) begin
            prdata_next[15:0] = lead_counter;
        end else if (a_lag) begin
            prdata_next[15:0] = lag_counter;
        end else if (a_sub) begin
            prdata_next[15:0] = sub_count;
        end else if (a_dbuf) begin
            prdata_next[15:0] = duty_buf_reg[dbuf_idx];
        end else if (a_dcmp) begin
            prdata_next[15:0] = duty_cmp_reg[dcmp_idx];
        end else begin
            pslverr_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // ==========================================================
    // Control and buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_start_bit_reg  <= 1'b0;
            mode_reg             <= 1'b0;
            dead_time_enable_reg <= 1'b1;
            mode_prev_reg        <= 1'b0;
        end else begin
            mode_prev_reg <= mode_reg;
            if (wr_en && a_ctrl) begin
                count_start_bit_reg  <= pwdata[cpwm_pkg::CTRL_START_BIT];
                mode_reg             <= pwdata[cpwm_pkg::CTRL_MODE_BIT];
                dead_time_enable_reg <= pwdata[cpwm_pkg::CTRL_DTE_BIT];
            end
        end
    end

    // Sub-counter, counters and compare registers have no write path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_time_value_reg   <= cpwm_pkg::RST_DEAD;
            cycle_data_buffer_reg <= cpwm_pkg::RST_BUF;
            half_cycle_buffer_reg <= cpwm_pkg::RST_BUF;
        end else if (wr_en) begin
            if (a_dead) begin
                dead_time_value_reg <= pwdata[15:0];
            end else if (a_cbuf) begin
                cycle_data_buffer_reg <= pwdata[15:0];
            end else if (a_hbuf) begin
                half_cycle_buffer_reg <= pwdata[15:0];
            end
        end
    end

    // Dead time is deliberately not part of the entry transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_data_value_reg <= cpwm_pkg::RST_BUF;
            half_cmp_reg         <= cpwm_pkg::RST_BUF;
        end else if (mode_entry) begin
            cycle_data_value_reg <= cycle_data_buffer_reg;
            half_cmp_reg         <= half_cycle_buffer_reg;
        end
    end

    // ==========================================================
    // Per-phase duty registers and outputs
    genvar g;
    generate
        for (g = 0; g < cpwm_pkg::PHASES; g++) begin : g_phase
            wire dbuf_wr = wr_en && a_dbuf && (dbuf_idx == 2'(g));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    duty_buf_reg[g]  <= cpwm_pkg::RST_BUF;
                    duty_temp_reg[g] <= cpwm_pkg::RST_BUF;
                    duty_cmp_reg[g]  <= cpwm_pkg::RST_BUF;
                end else begin
                    if (dbuf_wr) begin
                        duty_buf_reg[g] <= pwdata[15:0];
                    end
                    if (dbuf_wr) begin
                        duty_temp_reg[g] <= pwdata[15:0];
                    end
                    // Trough transfer keeps new duty away from mid-cycle glitches
                    if (mode_entry) begin
                        duty_cmp_reg[g] <= duty_buf_reg[g];
                    end else if (sub_reload) begin
                        duty_cmp_reg[g] <= duty_temp_reg[g];
                    end
                end
            end
            // Lead crosses first going up, lag first going down: dead time
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_pos[g]    <= 1'b0;
                    pwm_neg[g]    <= 1'b0;
                    duty_match[g] <= 1'b0;
                    temp_match[g] <= 1'b0;
                end else begin
                    pwm_pos[g]    <= mode_reg && (lag_counter > duty_cmp_reg[g]);
                    pwm_neg[g]    <= mode_reg && (lead_counter <= duty_cmp_reg[g]);
                    duty_match[g] <= sub_active && (sub_count == duty_cmp_reg[g]);
                    temp_match[g] <= sub_active && (sub_count == duty_temp_reg[g]);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Counter instances
    updown_counter u_lead (
        .pclk        (pclk),
        .presetn     (presetn),
        .load        (lead_load),
        .load_value  (dead_time_value_reg),
        .run         (run),
        .top         (half_cmp_reg),
        .bottom      (dead_time_value_reg),
        .count       (lead_counter),
        .counting_up (lead_up)
    );

    updown_counter u_lag (
        .pclk        (pclk),
        .presetn     (presetn),
        .load        (mode_entry),
        .load_value  (cpwm_pkg::ZERO),
        .run         (run),
        .top         (cycle_data_value_reg),
        .bottom      (cpwm_pkg::ZERO),
        .count       (lag_counter),
        .counting_up (lag_up)
    );

    wire crest_start  = lead_up && (lead_counter == cycle_data_value_reg);
    wire trough_start = !lead_up && !lag_up
                        && (lag_counter == dead_time_value_reg);

    dead_region_subcounter u_sub (
        .pclk             (pclk),
        .presetn          (presetn),
        .run              (run),
        .crest_start      (crest_start),
        .trough_start     (trough_start),
        .cycle_data_value (cycle_data_value_reg),
        .dead_time_value  (dead_time_value_reg),
        .half_cmp         (half_cmp_reg),
        .count            (sub_count),
        .active           (sub_active),
        .reload_pulse     (sub_reload)
    );

    // ==========================================================
    // Checks
    property p_lead_entry_load;
        @(posedge pclk) disable iff (!presetn)
        lead_load |=> (lead_counter == $past(dead_time_value_reg));
    endproperty
    a_lead_entry_load: assert property (p_lead_entry_load)
        else $error("lead counter not loaded with dead time on entry");

    property p_lead_top;
        @(posedge pclk) disable iff (!presetn)
        (run && !lead_load && lead_up && lead_counter == half_cmp_reg)
            |=> (!lead_up && lead_counter == $past(lead_counter) - 16'h0001);
    endproperty
    a_lead_top: assert property (p_lead_top)
        else $error("lead counter did not reverse at half compare");

    property p_lead_bottom;
        @(posedge pclk) disable iff (!presetn)
        (run && !lead_load && !lead_up && lead_counter == dead_time_value_reg)
            |=> lead_up;
    endproperty
    a_lead_bottom: assert property (p_lead_bottom)
        else $error("lead counter did not reverse at dead time");

    property p_lag_entry;
        @(posedge pclk) disable iff (!presetn)
        mode_entry |=> (lag_counter == 16'h0000 && lag_up);
    endproperty
    a_lag_entry: assert property (p_lag_entry)
        else $error("lag counter not zero after mode entry");

    property p_lag_top;
        @(posedge pclk) disable iff (!presetn)
        (run && !mode_entry && lag_up && lag_counter == cycle_data_value_reg)
            |=> !lag_up;
    endproperty
    a_lag_top: assert property (p_lag_top)
        else $error("lag counter did not reverse at cycle data");

    property p_lag_zero;
        @(posedge pclk) disable iff (!presetn)
        (run && !mode_entry && !lag_up && lag_counter == 16'h0000)
            |=> (lag_up && lag_counter == 16'h0001);
    endproperty
    a_lag_zero: assert property (p_lag_zero)
        else $error("lag counter did not reverse at zero");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!run && !mode_entry) |=> $stable(lag_counter) && $stable(sub_count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while stopped");

    property p_sub_reload;
        @(posedge pclk) disable iff (!presetn)
        (run && sub_reload) |=> (sub_count == $past(half_cmp_reg) && !sub_active);
    endproperty
    a_sub_reload: assert property (p_sub_reload)
        else $error("sub-counter not reloaded at zero");

    property p_match_gated;
        @(posedge pclk) disable iff (!presetn)
        !sub_active |=> (duty_match == 3'h0 && temp_match == 3'h0);
    endproperty
    a_match_gated: assert property (p_match_gated)
        else $error("duty match outside sub-counter activity");

    property p_entry_copy;
        @(posedge pclk) disable iff (!presetn)
        mode_entry |=> (cycle_data_value_reg == $past(cycle_data_buffer_reg)
                        && half_cmp_reg == $past(half_cycle_buffer_reg));
    endproperty
    a_entry_copy: assert property (p_entry_copy)
        else $error("buffers not copied on mode entry");

    property p_no_overlap;
        @(posedge pclk) disable iff (!presetn)
        (run && lag_counter <= lead_counter) |=> ((pwm_pos & pwm_neg) == 3'h0);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both phases of a pair driven");

    property p_crest_start;
        @(posedge pclk) disable iff (!presetn)
        (run && !sub_active && crest_start)
            |=> (sub_active && sub_count == $past(half_cmp_reg) - 16'h0001);
    endproperty
    a_crest_start: assert property (p_crest_start)
        else $error("sub-counter did not start down at the crest");

    property p_crest_clear;
        @(posedge pclk) disable iff (!presetn)
        (run && sub_active && sub_count == half_cmp_reg)
            |=> (sub_count == 16'h0000 && !sub_active);
    endproperty
    a_crest_clear: assert property (p_crest_clear)
        else $error("sub-counter not cleared at half compare");

    property p_trough_start;
        @(posedge pclk) disable iff (!presetn)
        (run && !sub_active && trough_start)
            |=> (sub_active && sub_count == $past(sub_count) + 16'h0001);
    endproperty
    a_trough_start: assert property (p_trough_start)
        else $error("sub-counter did not start up at the trough");
endmodule
`default_nettype wire

/* File: gate_driver_model.sv */
// Gate driver stand-in fed by the six phase outputs
`timescale 1ns/100ps
`default_nettype none
module gate_driver_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] pwm_pos,
    input  wire logic [2:0] pwm_neg,
    output var  int         shoot_through,
    output var  logic [2:0] upper_seen
);
    // =========================================================
    // Leg monitor
    // Both switches of one leg on together would short the supply
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shoot_through <= 0;
            upper_seen    <= 3'h0;
        end else begin
            if ((pwm_pos & pwm_neg) !== 3'h0) begin
                shoot_through <= shoot_through + 1;
            end
            upper_seen <= upper_seen | pwm_pos;
        end
    end
endmodule
`default_nettype wire

/* File: tb_complementary_pwm_counters.sv */
// Self-checking bench for the complementary PWM counter core
`timescale 1ns/100ps
`default_nettype none
module tb_complementary_pwm_counters;
    localparam logic [15:0] DEAD = 16'h0002;
    localparam logic [15:0] CYC  = 16'h000A;
    localparam logic [15:0] HALF = 16'h000C;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, up_m;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  pwm_pos, pwm_neg, duty_match, temp_match, seen;
    logic [15:0] lag_m, sub_m;
    int          shoot, n_errors, checks, sd, d_hits, t_hits;

    complementary_pwm_counters uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_pos(pwm_pos),
        .pwm_neg(pwm_neg), .duty_match(duty_match), .temp_match(temp_match));
    gate_driver_model drv (.pclk(pclk), .presetn(presetn), .pwm_pos(pwm_pos),
        .pwm_neg(pwm_neg), .shoot_through(shoot), .upper_seen(seen));

    // =========================================================
    // Shared tasks
    task check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen_v, exp_v);
        end
    endtask

    task test_done;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One idle edge after each transfer so psel is never set twice in a step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rd_chk(input logic [7:0] a, input logic [15:0] exp_v);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, {16'h0000, exp_v});
    endtask

    // =========================================================
    // Scenarios
    task t_reset;
        rd_chk(cpwm_pkg::OFF_DEAD, cpwm_pkg::RST_DEAD);
        rd_chk(cpwm_pkg::OFF_LAG, cpwm_pkg::RST_CNT);
        apb(1'b0, 8'h24, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, cpwm_pkg::OFF_SUB, 32'h0000_1234);
        rd_chk(cpwm_pkg::OFF_SUB, cpwm_pkg::RST_CNT);
        apb(1'b1, cpwm_pkg::OFF_LEAD, 32'h0000_0055);
        rd_chk(cpwm_pkg::OFF_LEAD, cpwm_pkg::RST_CNT);
    endtask

    task t_entry;
        apb(1'b1, cpwm_pkg::OFF_DEAD, {16'h0000, DEAD});
        apb(1'b1, cpwm_pkg::OFF_CYC_BUF, {16'h0000, CYC});
        apb(1'b1, cpwm_pkg::OFF_HALF_BUF, {16'h0000, HALF});
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, cpwm_pkg::OFF_DUTY_BUF0 + 8'(4 * c), 32'(5 + c));
        end
        rd_chk(cpwm_pkg::OFF_CYC_DATA, cpwm_pkg::RST_BUF);
        apb(1'b1, cpwm_pkg::OFF_CTRL, 32'h0000_0006);
        rd_chk(cpwm_pkg::OFF_CYC_DATA, CYC);
        rd_chk(cpwm_pkg::OFF_HALF_CMP, HALF);
        rd_chk(cpwm_pkg::OFF_DUTY_CMP0, 16'h0005);
        rd_chk(cpwm_pkg::OFF_LEAD, DEAD);
        rd_chk(cpwm_pkg::OFF_LAG, 16'h0000);
        repeat (5) @(posedge pclk);
        rd_chk(cpwm_pkg::OFF_LEAD, DEAD);
        check({26'h0, pwm_pos, pwm_neg}, 32'h0000_0007);
    endtask

    // Run w+3 edges between start and stop writes, then compare with own model
    task t_run(input int w);
        apb(1'b1, cpwm_pkg::OFF_CTRL, 32'h0000_0007);
        repeat (w) @(posedge pclk);
        apb(1'b1, cpwm_pkg::OFF_CTRL, 32'h0000_0006);
        for (int s = 0; s < w + 3; s++) begin
            case (sd)
                0: begin
                    if (up_m && lag_m + DEAD == CYC) begin
                        sd = 1;
                        sub_m = HALF - 16'h0001;
                    end else if (!up_m && lag_m == DEAD) begin
                        sd = 3;
                        sub_m = 16'h0001;
                    end
                end
                1: begin
                    sd = (sub_m == CYC) ? 2 : 1;
                    sub_m = (sd == 2) ? sub_m + 16'h0001 : sub_m - 16'h0001;
                end
                2: begin
                    sd = (sub_m == HALF) ? 0 : 2;
                    sub_m = (sd == 0) ? 16'h0000 : sub_m + 16'h0001;
                end
                3: begin
                    sd = (sub_m == DEAD) ? 4 : 3;
                    sub_m = (sd == 4) ? sub_m - 16'h0001 : sub_m + 16'h0001;
                end
                default: begin
                    sd = (sub_m == 16'h0000) ? 0 : 4;
                    sub_m = (sd == 0) ? HALF : sub_m - 16'h0001;
                end
            endcase
            if (up_m && lag_m == CYC) up_m = 1'b0;
            else if (!up_m && lag_m == 16'h0000) up_m = 1'b1;
            lag_m = up_m ? lag_m + 16'h0001 : lag_m - 16'h0001;
        end
        rd_chk(cpwm_pkg::OFF_LAG, lag_m);
        rd_chk(cpwm_pkg::OFF_LEAD, lag_m + DEAD);
        rd_chk(cpwm_pkg::OFF_SUB, sub_m);
    endtask

    // New duty lands at the trough reload; matches count only while sub runs
    task t_duty;
        apb(1'b1, cpwm_pkg::OFF_DUTY_BUF0, 32'h0000_0001);
        rd_chk(cpwm_pkg::OFF_DUTY_CMP0, 16'h0005);
        t_run(40);
        rd_chk(cpwm_pkg::OFF_DUTY_CMP0, 16'h0001);
        check(32'(d_hits), 32'h0000_0002);
        check(32'(t_hits), 32'h0000_0004);
    endtask

    always @(negedge pclk) begin
        if (duty_match[0] === 1'b1) d_hits++;
        if (temp_match[0] === 1'b1) t_hits++;
    end

    // =========================================================
    // Clock, reset, sequence and watchdog
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_errors = 0;
        checks = 0;
        lag_m = 16'h0000;
        up_m = 1'b1;
        sub_m = 16'h0000;
        sd = 0;
        d_hits = 0;
        t_hits = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_entry();
        for (int w = 0; w < 8; w++) t_run(w);
        t_duty();
        check(32'(shoot), 32'h0000_0000);
        check({29'h0, seen}, 32'h0000_0007);
        test_done();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
